/* common/usart_modes_pkg.sv */
// Constants shared by the serial special-mode block
package usart_modes_pkg;
   // ----------------------------------------
   // Operating mode codes
   // ----------------------------------------
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_RS485 = 4'h1;
   localparam logic [3:0] MODE_T0 = 4'h4;
   localparam logic [3:0] MODE_T1 = 4'h6;
   localparam logic [3:0] MODE_IRDA = 4'h8;
   // ----------------------------------------
   // Channel test modes
   // ----------------------------------------
   localparam logic [1:0] CH_NORMAL = 2'h0;
   localparam logic [1:0] CH_ECHO = 2'h1;
   localparam logic [1:0] CH_LOCAL = 2'h2;
   localparam logic [1:0] CH_REMOTE = 2'h3;
   // ----------------------------------------
   // Limits and pulse fraction
   // ----------------------------------------
   localparam int MAX_SENDS = 8;
   localparam int PULSE_NUM = 3;
   localparam int PULSE_DEN = 16;
   localparam int FILT_W = 8;
endpackage : usart_modes_pkg

/* tb/line_partner.sv */
// Far-side line model: receive line resting at lvl with timed low pulses
`timescale 1ns/1ns
// ------
// Line partner
// ------
module line_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pulse request
   input wire logic start,
   input wire logic [7:0] len,
   input wire logic lvl,
   // Line
   output logic rxd_pin
);
   logic [7:0] cnt_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 8'h00;
      end else if (start) begin
         cnt_r <= len;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
   // Between pulses the line is driven to lvl, so a finished pulse returns to the resting level
   assign rxd_pin = (cnt_r != 8'h00) ? 1'b0 : lvl;
endmodule : line_partner

/* tb/usart_modes_tb.sv */
// Self-checking bench for the serial special-mode block
`timescale 1ns/1ns
module usart_modes_tb;
   logic clk = 1'b0, rst = 1'b1, clr = 1'b0, nack_en = 1'b0;
   logic tx_nack = 1'b0, tx_done = 1'b0, rx_done = 1'b0, rx_bad = 1'b0;
   logic tx_ser = 1'b1, tx_emp = 1'b1, rx_en = 1'b0, tx_en = 1'b0;
   logic p_start = 1'b0, p_lvl = 1'b1, rs_s, nk_s, ac_s, ex_tx, ex_rx;
   logic [3:0] op_mode = 4'h0;
   logic [2:0] max_it = 3'h0, lim, iter;
   logic [1:0] ch_mode = 2'h0;
   logic [7:0] p_len = 8'h00;
   logic [31:0] seed = 32'hf6a2;
   logic rx_ser, rs, nk, ac, one_stop, pe, rep, rxd, txd, rts, pinv;
   int mismatches = 0, n_tests = 0, cycles = 0, it_m = 0, lo_rx = 0, lo_tx = 0;
   always #50 clk = ~clk;
   // ------
   // Design and far side
   // ------
   usart_modes #(.BIT_CYC_W(16)) uut (.clk(clk), .rst(rst), .op_mode(op_mode),
      .channel_test_mode(ch_mode), .max_iteration(max_it), .nack_limit_enable(nack_en),
      .infrared_filter_reg(8'h06), .bit_cycles(16'h0020), .clear_repeat_flag_cmd(clr),
      .tx_serial(tx_ser), .tx_empty_flag(tx_emp), .tx_char_done(tx_done),
      .tx_nack_seen(tx_nack), .rx_char_done(rx_done), .rx_parity_bad(rx_bad),
      .rx_enable(rx_en), .tx_enable(tx_en), .rx_serial(rx_ser), .tx_resend(rs),
      .rx_send_nack(nk), .rx_accept(ac), .tx_parity_invert(pinv), .one_stop_bit(one_stop),
      .parity_error_flag(pe), .repeat_flag(rep), .iteration_count(iter),
      .rxd_pin(rxd), .txd_pin(txd), .rts_pin(rts));
   line_partner far (.clk(clk), .rst(rst), .start(p_start), .len(p_len), .lvl(p_lvl),
      .rxd_pin(rxd));
   // ------
   // Helpers
   // ------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   // Strobes {clear, nack, char done, rx done}; combinational answers caught mid-cycle
   task automatic pulse(input logic [3:0] v, input logic bad);
      @(posedge clk);
      {clr, tx_nack, tx_done, rx_done} <= v;
      rx_bad <= bad;
      @(negedge clk);
      rs_s = rs;
      nk_s = nk;
      ac_s = ac;
      @(posedge clk);
      {clr, tx_nack, tx_done, rx_done} <= 4'h0;
      rx_bad <= 1'b0;
      @(negedge clk);
   endtask : pulse
   task automatic nack_once;
      logic e;
      e = (max_it != 3'h0) && (it_m < max_it);
      pulse(4'h4, 1'b0);
      chk("tx_resend", {15'h0, e}, {15'h0, rs_s});
      if (e) it_m++;
      if (e) chk("iteration_count", it_m[15:0], {13'h0, iter});
   endtask : nack_once
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end
   always @(negedge clk) begin
      lo_rx += !rx_ser;
      lo_tx += !txd;
   end
   // ------
   // Scenarios
   // ------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      op_mode <= usart_modes_pkg::MODE_T0;
      for (int li = 0; li < 3; li++) begin
         lim = (li == 0) ? 3'h0 : (li == 1) ? 3'h2 : 3'h7;
         @(posedge clk);
         max_it <= lim;
         pulse(4'h8, 1'b0);
         it_m = 0;
         if (lim == 3'h7) begin
            repeat (3) nack_once();
            pulse(4'h2, 1'b0);
            chk("iteration_count", 16'h0, {13'h0, iter});
            it_m = 0;
         end
         repeat (lim + 1) nack_once();
         if (lim != 3'h0) chk("repeat_flag", 16'h1, {15'h0, rep});
      end
      @(posedge clk);
      op_mode <= usart_modes_pkg::MODE_NORMAL;
      pulse(4'h8, 1'b0);
      chk("repeat_flag", 16'h1, {15'h0, rep});
      @(posedge clk);
      op_mode <= usart_modes_pkg::MODE_T0;
      nack_en <= 1'b1;
      max_it <= 3'h3;
      pulse(4'h8, 1'b0);
      chk("repeat_flag", 16'h0, {15'h0, rep});
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1, 1'b1);
         chk("rx_send_nack", {15'h0, i < 3}, {15'h0, nk_s});
         chk("rx_accept", {15'h0, i == 3}, {15'h0, ac_s});
      end
      chk("repeat_flag", 16'h1, {15'h0, rep});
      @(posedge clk);
      op_mode <= usart_modes_pkg::MODE_T1;
      nack_en <= 1'b0;
      pulse(4'h8, 1'b0);
      chk("repeat_flag", 16'h0, {15'h0, rep});
      pulse(4'h1, 1'b0);
      chk("parity_error_flag", 16'h0, {15'h0, pe});
      pulse(4'h1, 1'b1);
      chk("parity_error_flag", 16'h1, {15'h0, pe});
      chk("one_stop_bit", 16'h1, {15'h0, one_stop});
      chk("tx_parity_invert", 16'h0, {15'h0, pinv});
      // Infrared, receive then transmit direction; short glitch must be filtered out
      @(posedge clk);
      op_mode <= usart_modes_pkg::MODE_IRDA;
      rx_en <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         p_start <= 1'b1;
         p_len <= (k == 0) ? 8'h04 : 8'h14;
         lo_rx = 0;
         @(posedge clk);
         p_start <= 1'b0;
         repeat (90) @(posedge clk);
         chk("rx_serial low", (k == 0) ? 16'h0 : 16'h20, lo_rx[15:0]);
      end
      @(posedge clk);
      rx_en <= 1'b0;
      tx_en <= 1'b1;
      tx_ser <= 1'b0;
      lo_tx = 0;
      repeat (32) @(posedge clk);
      tx_ser <= 1'b1;
      repeat (60) @(posedge clk);
      it_m = 32 * usart_modes_pkg::PULSE_NUM / usart_modes_pkg::PULSE_DEN;
      chk("txd_pin pulse", it_m[15:0], lo_tx[15:0]);
      @(posedge clk);
      op_mode <= usart_modes_pkg::MODE_RS485;
      tx_emp <= 1'b0;
      repeat (3) @(negedge clk);
      chk("rts_pin", 16'h1, {15'h0, rts});
      @(posedge clk);
      tx_emp <= 1'b1;
      repeat (3) @(negedge clk);
      chk("rts_pin", 16'h0, {15'h0, rts});
      @(posedge clk);
      op_mode <= usart_modes_pkg::MODE_NORMAL;
      rx_en <= 1'b1;
      for (int m = 0; m < 16; m++) begin
         @(posedge clk);
         seed = xs(seed);
         ch_mode <= m[3:2];
         p_lvl <= seed[0];
         tx_ser <= seed[1];
         repeat (6) @(negedge clk);
         ex_tx = (m[3:2] == 2'h2) ? 1'b1 : (m[3:2] == 2'h0) ? seed[1] : seed[0];
         ex_rx = (m[3:2] == 2'h2) ? seed[1] : seed[0];
         chk("txd_pin", {15'h0, ex_tx}, {15'h0, txd});
         if (m < 12) chk("rx_serial", {15'h0, ex_rx}, {15'h0, rx_ser});
      end
      test_done();
   end
endmodule : usart_modes_tb

/* verilog/usart_modes.sv */
// Special modes of a serial transceiver: smart card, infrared, RS485, test modes
`timescale 1ns/1ns
module usart_modes #(
   parameter int BIT_CYC_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Configuration
   input wire logic [3:0] op_mode,
   input wire logic [1:0] channel_test_mode,
   input wire logic [2:0] max_iteration,
   input wire logic nack_limit_enable,
   input wire logic [7:0] infrared_filter_reg,
   input wire logic [BIT_CYC_W-1:0] bit_cycles,
   input wire logic clear_repeat_flag_cmd,
   // Core transmitter and receiver
   input wire logic tx_serial,
   input wire logic tx_empty_flag,
   input wire logic tx_char_done,
   input wire logic tx_nack_seen,
   input wire logic rx_char_done,
   input wire logic rx_parity_bad,
   input wire logic rx_enable,
   input wire logic tx_enable,
   output logic rx_serial,
   output logic tx_resend,
   output logic rx_send_nack,
   output logic rx_accept,
   output logic tx_parity_invert,
   output logic one_stop_bit,
   output logic parity_error_flag,
   output logic repeat_flag,
   output logic [2:0] iteration_count,
   // Pins
   input wire logic rxd_pin,
   output logic txd_pin,
   output logic rts_pin
);
   localparam logic [BIT_CYC_W-1:0] ONE_C = {{(BIT_CYC_W-1){1'b0}}, 1'b1};
   // Divide by shifting, so the denominator has to be a power of two
   localparam int PULSE_SH = $clog2(usart_modes_pkg::PULSE_DEN);
   localparam logic [BIT_CYC_W+1:0] PULSE_MUL = (BIT_CYC_W+2)'(usart_modes_pkg::PULSE_NUM);
   if (BIT_CYC_W < 5) begin : g_width_bad
      $error("bit_cycles too narrow");
   end
   if ((1 << PULSE_SH) != usart_modes_pkg::PULSE_DEN) begin : g_den_bad
      $error("pulse denominator not a power of two");
   end
   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   logic rx_s1_r, rx_s2_r, rx_s3_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
         rx_s3_r <= 1'b1;
      end else begin
         rx_s1_r <= rxd_pin;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
      end
   end
   wire rx_fall = rx_s3_r & ~rx_s2_r;
   wire rx_rise = ~rx_s3_r & rx_s2_r;
   wire is_t0 = (op_mode == usart_modes_pkg::MODE_T0);
   wire is_t1 = (op_mode == usart_modes_pkg::MODE_T1);
   wire is_sc = is_t0 | is_t1;
   wire is_ir = (op_mode == usart_modes_pkg::MODE_IRDA);
   // ----------------------------------------
   // T=0 transmit repetition
   // ----------------------------------------
   logic [2:0] iter_r;
   logic [2:0] nack_cnt_r;
   logic flag_r;
   wire tx_limit_hit = tx_nack_seen & (iter_r == max_iteration);
   wire rx_limit_hit = rx_char_done & rx_parity_bad & nack_limit_enable
                       & (nack_cnt_r == max_iteration);
   assign tx_resend = is_t0 & tx_nack_seen & (max_iteration != 3'h0)
                      & (iter_r < max_iteration);
   always_ff @(posedge clk) begin
      if (rst) begin
         iter_r <= 3'h0;
      end else if (!is_t0 || (tx_char_done && !tx_nack_seen)) begin
         iter_r <= 3'h0;
      end else if (tx_resend) begin
         iter_r <= iter_r + 3'h1;
      end else if (tx_nack_seen) begin
         iter_r <= 3'h0;
      end
   end
   assign iteration_count = iter_r;
   // ----------------------------------------
   // T=0 receive NACK limiting
   // ----------------------------------------
   wire rx_bad_t0 = is_t0 & rx_char_done & rx_parity_bad;
   assign rx_send_nack = rx_bad_t0 & ~rx_limit_hit;
   assign rx_accept = is_sc & rx_char_done & (~rx_parity_bad | rx_limit_hit);
   always_ff @(posedge clk) begin
      if (rst) begin
         nack_cnt_r <= 3'h0;
      end else if (!is_t0 || (rx_char_done && (!rx_parity_bad || rx_limit_hit))) begin
         nack_cnt_r <= 3'h0;
      end else if (rx_bad_t0) begin
         nack_cnt_r <= nack_cnt_r + 3'h1;
      end
   end
   // ----------------------------------------
   // Repeat flag, set wins over clear
   // ----------------------------------------
   wire flag_set = is_t0 & (max_iteration != 3'h0) & (tx_limit_hit | rx_limit_hit);
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if (flag_set) begin
         flag_r <= 1'b1;
      end else if (clear_repeat_flag_cmd && is_sc) begin
         flag_r <= 1'b0;
      end
   end
   assign repeat_flag = flag_r;
   // ----------------------------------------
   // T=1 stop bit and smart-card parity flag
   // ----------------------------------------
   logic parity_error_flag_r;
   assign one_stop_bit = is_t1;
   assign tx_parity_invert = 1'b0;
   always_ff @(posedge clk) begin
      if (rst) begin
         parity_error_flag_r <= 1'b0;
      end else if (is_sc && rx_char_done && rx_parity_bad) begin
         parity_error_flag_r <= 1'b1;
      end else if (clear_repeat_flag_cmd && is_sc) begin
         parity_error_flag_r <= 1'b0;
      end
   end
   assign parity_error_flag = parity_error_flag_r;
   // ----------------------------------------
   // Infrared modulator
   // ----------------------------------------
   logic [BIT_CYC_W-1:0] mod_cnt_r;
   logic tx_prev_r, ir_tx_r;
   wire [BIT_CYC_W+1:0] pulse_prod = {2'b00, bit_cycles} * PULSE_MUL;
   wire [BIT_CYC_W-1:0] pulse_len = BIT_CYC_W'(pulse_prod >> PULSE_SH);
   always_ff @(posedge clk) begin
      if (rst) begin
         mod_cnt_r <= '0;
         tx_prev_r <= 1'b1;
         ir_tx_r <= 1'b0;
      end else begin
         tx_prev_r <= tx_serial;
         if (is_ir && tx_enable && !tx_serial && (tx_prev_r || mod_cnt_r == bit_cycles)) begin
            mod_cnt_r <= ONE_C;
            ir_tx_r <= 1'b1;
         end else if (mod_cnt_r != '0) begin
            mod_cnt_r <= (mod_cnt_r == bit_cycles) ? '0 : mod_cnt_r + ONE_C;
            if (mod_cnt_r >= pulse_len) ir_tx_r <= 1'b0;
         end else begin
            ir_tx_r <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // Infrared demodulator filter
   // ----------------------------------------
   logic [7:0] filt_r;
   logic filt_run_r;
   logic [BIT_CYC_W-1:0] low_cnt_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         filt_r <= 8'h00;
         filt_run_r <= 1'b0;
      end else if (rx_rise || !is_ir || !rx_enable) begin
         filt_r <= infrared_filter_reg;
         filt_run_r <= 1'b0;
      end else if (rx_fall) begin
         filt_r <= infrared_filter_reg;
         filt_run_r <= 1'b1;
      end else if (filt_run_r) begin
         if (filt_r == 8'h00) filt_run_r <= 1'b0;
         else filt_r <= filt_r - 8'h01;
      end
   end
   wire filt_hit = filt_run_r & (filt_r == 8'h00) & ~rx_rise;
   always_ff @(posedge clk) begin
      if (rst || !is_ir || !rx_enable) begin
         low_cnt_r <= '0;
      end else if (filt_hit) begin
         low_cnt_r <= bit_cycles;
      end else if (low_cnt_r != '0) begin
         low_cnt_r <= low_cnt_r - ONE_C;
      end
   end
   wire ir_rx = (low_cnt_r == '0);
   // ----------------------------------------
   // Channel routing and RS485
   // ----------------------------------------
   wire rx_line = is_ir ? ir_rx : rx_s2_r;
   wire tx_line = is_ir ? ~ir_tx_r : tx_serial;
   logic rxo_r, txo_r, rts_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         rxo_r <= 1'b1;
         txo_r <= 1'b1;
      end else begin
         unique case (channel_test_mode)
            usart_modes_pkg::CH_NORMAL: begin
               rxo_r <= rx_line;
               txo_r <= tx_line;
            end
            usart_modes_pkg::CH_ECHO: begin
               rxo_r <= rx_line;
               txo_r <= rx_s2_r;
            end
            usart_modes_pkg::CH_LOCAL: begin
               rxo_r <= tx_serial;
               txo_r <= 1'b1;
            end
            usart_modes_pkg::CH_REMOTE: begin
               rxo_r <= 1'b1;
               txo_r <= rx_s2_r;
            end
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rts_r <= 1'b0;
      end else begin
         rts_r <= (op_mode == usart_modes_pkg::MODE_RS485) & ~tx_empty_flag;
      end
   end
   assign rx_serial = rxo_r;
   assign txd_pin = txo_r;
   assign rts_pin = rts_r;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_rts_follows;
      @(posedge clk) disable iff (rst)
      (op_mode == usart_modes_pkg::MODE_RS485) ##1 (op_mode == usart_modes_pkg::MODE_RS485)
      |-> rts_pin == ~$past(tx_empty_flag);
   endproperty
   a_rts_follows: assert property (p_rts_follows) else $error("rts not inverse of empty");
   property p_flag_clear;
      @(posedge clk) disable iff (rst)
      clear_repeat_flag_cmd && is_sc && !flag_set |=> !repeat_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
   property p_flag_set;
      @(posedge clk) disable iff (rst) flag_set |=> repeat_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");
   property p_no_clear_out;
      @(posedge clk) disable iff (rst) repeat_flag && !is_sc |=> repeat_flag;
   endproperty
   a_no_clear_out: assert property (p_no_clear_out) else $error("flag lost");
   property p_resend_limit;
      @(posedge clk) disable iff (rst)
      tx_resend |-> iteration_count < max_iteration
         ##1 iteration_count == $past(iteration_count) + 3'h1;
   endproperty
   a_resend_limit: assert property (p_resend_limit) else $error("too many resends");
   property p_remote;
      @(posedge clk) disable iff (rst)
      channel_test_mode == usart_modes_pkg::CH_REMOTE |=> txd_pin == $past(rx_s2_r) && rx_serial;
   endproperty
   a_remote: assert property (p_remote) else $error("remote loop wrong");
   property p_local;
      @(posedge clk) disable iff (rst)
      channel_test_mode == usart_modes_pkg::CH_LOCAL |=> txd_pin && rx_serial == $past(tx_serial);
   endproperty
   a_local: assert property (p_local) else $error("local loop wrong");
   sequence s_fhit;
      is_ir && filt_hit;
   endsequence
   property p_ir_low;
      @(posedge clk) disable iff (rst) s_fhit ##1 (is_ir && rx_enable) |-> !ir_rx;
   endproperty
   a_ir_low: assert property (p_ir_low) else $error("demod not low");
   property p_nack_accept;
      @(posedge clk) disable iff (rst) rx_limit_hit && is_t0 |-> rx_accept && !rx_send_nack;
   endproperty
   a_nack_accept: assert property (p_nack_accept) else $error("nack limit ignored");
   property p_ack_clears;
      @(posedge clk) disable iff (rst)
      is_t0 && tx_char_done && !tx_nack_seen |=> iteration_count == 3'h0;
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("count kept after ack");
   property p_resend_gate;
      @(posedge clk) disable iff (rst)
      !is_t0 || max_iteration == 3'h0 |-> !tx_resend;
   endproperty
   a_resend_gate: assert property (p_resend_gate) else $error("resend while off");
   property p_normal;
      @(posedge clk) disable iff (rst)
      channel_test_mode == usart_modes_pkg::CH_NORMAL && !is_ir
      |=> txd_pin == $past(tx_serial) && rx_serial == $past(rx_s2_r);
   endproperty
   a_normal: assert property (p_normal) else $error("normal routing wrong");
   property p_echo;
      @(posedge clk) disable iff (rst)
      channel_test_mode == usart_modes_pkg::CH_ECHO |=> txd_pin == $past(rx_s2_r);
   endproperty
   a_echo: assert property (p_echo) else $error("echo routing wrong");
   property p_filt_reload;
      @(posedge clk) disable iff (rst)
      is_ir && rx_rise |=> filt_r == $past(infrared_filter_reg) && !filt_run_r;
   endproperty
   a_filt_reload: assert property (p_filt_reload) else $error("filter not reloaded");
   property p_filt_count;
      @(posedge clk) disable iff (rst)
      is_ir && rx_enable && filt_run_r && !rx_rise && !rx_fall && filt_r != 8'h00
      |=> filt_r == $past(filt_r) - 8'h01;
   endproperty
   a_filt_count: assert property (p_filt_count) else $error("filter not counting");
   property p_parity_set;
      @(posedge clk) disable iff (rst)
      is_t1 && rx_char_done && rx_parity_bad |=> parity_error_flag;
   endproperty
   a_parity_set: assert property (p_parity_set) else $error("parity flag not set");
   property p_ir_pulse;
      @(posedge clk) disable iff (rst)
      ir_tx_r && pulse_len != '0 |-> mod_cnt_r != '0 && mod_cnt_r <= pulse_len;
   endproperty
   a_ir_pulse: assert property (p_ir_pulse) else $error("infrared pulse too long");
endmodule : usart_modes
